// [design/usb_attach_pullup_sequencer.v]
// Attach, bus reset and pull resistor sequencing for the bridge transceiver
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "usb_attach_defs.vh"

module usb_attach_pullup_sequencer (
   input wire sys_clk, // 20 MHz timebase
   input wire reset_n, // Asynchronous reset, active low
   input wire [3:0] reg_addr, // Register byte address
   input wire [7:0] reg_wdata, // Register write data
   input wire reg_write, // Write strobe
   input wire reg_read, // Read strobe
   output reg [7:0] reg_rdata, // Read data, cycle after strobe
   input wire [2:0] mode_strap, // Configuration straps
   input wire up_dplus, // Upstream D+ level
   input wire up_dminus, // Upstream D- level
   input wire down_dplus, // Downstream D+ level
   output reg section7_pullup_switch, // Section-7 pull-up connected
   output reg section7_pullup_weak, // Section-7 pull-up at 2.2k, else 1.2k
   output reg icusb_pullup_switch, // IC_USB host pull-up connected
   output reg icusb_pullup_strong, // IC_USB pull-up at 2k, else 50k
   output reg [1:0] host_side_pulldown, // Host-side pull-downs, bit0 D+, bit1 D-
   output reg [1:0] downstream_facing_pulldown, // Downstream pull-downs, bit0 D+, bit1 D-
   output reg down_dplus_out, // Downstream D+ drive level
   output reg down_dplus_oe, // Downstream D+ drive enable
   output reg attach_confirmed // Peripheral attach forwarded upstream
);

// ****************************************
// States and timing
// ****************************************
localparam [4:0] ST_IDLE = 5'b00001;
localparam [4:0] ST_DEBOUNCE = 5'b00010;
localparam [4:0] ST_ATTACHED = 5'b00100;
localparam [4:0] ST_BUS_RESET = 5'b01000;
localparam [4:0] ST_RECOVER = 5'b10000;

// Whole-number counts, cut to the counter width
localparam integer DEBOUNCE_NUM = `ATTACH_DEBOUNCE_CYC;
localparam integer LONG_SE0_NUM = `LONG_SE0_CYC;
localparam integer DRIVE_DELAY_NUM = `DRIVE_DELAY_CYC;
localparam integer HOLD_NUM = `HOLD_CYC;
localparam [4:0] DEBOUNCE_CYC = DEBOUNCE_NUM[4:0];
localparam [4:0] LONG_SE0_CYC = LONG_SE0_NUM[4:0];
localparam [4:0] DRIVE_DELAY_CYC = DRIVE_DELAY_NUM[4:0];
localparam [4:0] HOLD_CYC = HOLD_NUM[4:0];

// ****************************************
// Declarations
// ****************************************
wire [5:0] pins_level;
wire [2:0] strap;
wire up_dp;
wire up_dm;
wire down_dp;
wire se0;
wire converter_mode;
wire section7_mode;
wire token_mode;
wire seq_active;

reg [7:0] ctrl;
reg [4:0] state;
reg [4:0] cnt;
reg [4:0] up_cnt;
reg [4:0] down_cnt;
reg up_seen;
reg up_done;
reg down_done;
reg long_se0;

reg [4:0] next_state;
reg [4:0] next_cnt;
reg [4:0] next_up_cnt;
reg [4:0] next_down_cnt;
reg next_up_seen;
reg next_up_done;
reg next_down_done;
reg next_long_se0;
reg next_s7_sw;
reg next_s7_weak;
reg next_ic_sw;
reg next_ic_strong;
reg [1:0] next_host_pd;
reg [1:0] next_down_pd;
reg next_dp_out;
reg next_dp_oe;
reg next_attach;

// ****************************************
// Pin synchronisers
// ****************************************
pin_filter #(
   .WIDTH(6)
) u_pin_filter (
   .sys_clk(sys_clk),
   .reset_n(reset_n),
   .pin_in({mode_strap, down_dplus, up_dminus, up_dplus}),
   .level_out(pins_level)
);

assign up_dp = pins_level[0];
assign up_dm = pins_level[1];
assign down_dp = pins_level[2];
assign strap = pins_level[5:3];
assign se0 = !up_dp && !up_dm;

// ****************************************
// Mode decode
// ****************************************
// Digital upstream codes and the unused code leave the sequencer idle
assign converter_mode = (strap == `STRAP_CONVERTER);
assign section7_mode = (strap == `STRAP_SECTION7);
assign token_mode = section7_mode && ctrl[`CTRL_TOKEN_BIT];
assign seq_active = ctrl[`CTRL_ENABLE_BIT] && (converter_mode || section7_mode);

// ****************************************
// Register port
// ****************************************
always @(posedge sys_clk or negedge reset_n) begin
   if (!reset_n) begin
      ctrl <= `CTRL_RESET;
      reg_rdata <= 8'h00;
   end else begin
      if (reg_write && (reg_addr == `REG_CTRL)) begin
         ctrl <= {6'h00, reg_wdata[1:0]};
      end
      if (reg_read) begin
         case (reg_addr)
            `REG_CTRL: reg_rdata <= ctrl;
            `REG_STATUS: reg_rdata <= {2'h0, strap, long_se0, down_dplus_oe, attach_confirmed};
            `REG_STATE: reg_rdata <= {3'h0, state};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
end

// ****************************************
// Sequencer next state
// ****************************************
always @* begin
   next_state = state;
   next_cnt = cnt;
   next_up_cnt = up_cnt;
   next_down_cnt = down_cnt;
   next_up_seen = up_seen;
   next_up_done = up_done;
   next_down_done = down_done;
   next_long_se0 = long_se0;
   next_s7_sw = section7_pullup_switch;
   next_s7_weak = section7_pullup_weak;
   next_ic_sw = icusb_pullup_switch;
   next_ic_strong = icusb_pullup_strong;
   next_host_pd = host_side_pulldown;
   next_down_pd = downstream_facing_pulldown;
   next_dp_out = down_dplus_out;
   next_dp_oe = down_dplus_oe;
   next_attach = attach_confirmed;
   // No upstream drive exists here, so no wake-up can originate
   if (!seq_active) begin
      next_state = ST_IDLE;
      next_cnt = 5'h00;
      next_long_se0 = 1'b0;
      next_s7_sw = 1'b0;
      next_s7_weak = 1'b0;
      next_ic_sw = 1'b0;
      next_ic_strong = 1'b0;
      next_host_pd = 2'b00;
      next_down_pd = 2'b00;
      next_dp_out = 1'b0;
      next_dp_oe = 1'b0;
      next_attach = 1'b0;
   end else begin
      case (state)
         ST_IDLE: begin
            // Pre-attach resistor set for the active mode
            next_s7_sw = 1'b0;
            next_s7_weak = 1'b0;
            next_ic_sw = 1'b0;
            next_ic_strong = 1'b0;
            next_host_pd = 2'b11;
            next_down_pd = converter_mode ? 2'b11 : 2'b00;
            next_dp_out = 1'b0;
            next_dp_oe = 1'b0;
            next_attach = 1'b0;
            next_long_se0 = 1'b0;
            next_cnt = 5'h00;
            next_up_seen = 1'b0;
            if (down_dp) begin
               next_state = ST_DEBOUNCE;
            end
         end
         ST_DEBOUNCE: begin
            if (!down_dp) begin
               next_state = ST_IDLE;
               next_cnt = 5'h00;
            end else if (cnt == DEBOUNCE_CYC) begin
               next_state = ST_ATTACHED;
               next_attach = 1'b1;
               next_cnt = 5'h00;
               if (converter_mode) begin
                  next_ic_sw = 1'b1;
                  next_ic_strong = 1'b1;
                  next_host_pd = {host_side_pulldown[1], 1'b0};
               end else begin
                  next_s7_sw = 1'b1;
                  next_s7_weak = 1'b0;
               end
            end else begin
               next_cnt = cnt + 5'h01;
            end
         end
         ST_ATTACHED: begin
            next_dp_oe = 1'b0;
            // Line still rising after connect is not a reset
            next_up_seen = up_seen || up_dp;
            if (se0 && up_seen) begin
               next_state = ST_BUS_RESET;
               next_cnt = 5'h00;
               next_dp_out = 1'b0;
               next_dp_oe = 1'b1;
               if (token_mode) begin
                  next_s7_weak = 1'b1;
               end else if (converter_mode) begin
                  next_ic_strong = 1'b1;
               end
            end else if (!down_dp) begin
               next_state = ST_IDLE;
            end
         end
         ST_BUS_RESET: begin
            next_dp_out = 1'b0;
            next_dp_oe = 1'b1;
            if (!se0) begin
               next_state = ST_RECOVER;
               next_up_seen = 1'b0;
               next_up_done = 1'b0;
               next_down_done = 1'b0;
               next_up_cnt = 5'h00;
               next_down_cnt = 5'h00;
               // Converter pull-up is still the strong 2k one here
               if (converter_mode) begin
                  next_ic_sw = 1'b1;
                  next_ic_strong = 1'b1;
               end
            end else if (cnt == LONG_SE0_CYC) begin
               next_long_se0 = 1'b1;
               next_host_pd = 2'b00;
            end else begin
               next_cnt = cnt + 5'h01;
            end
         end
         ST_RECOVER: begin
            if (se0 && !up_seen) begin
               // Host re-entered SE0 before the line rose
               next_state = ST_BUS_RESET;
            end else begin
               if (!up_seen) begin
                  if (up_dp) begin
                     next_up_seen = 1'b1;
                     next_up_cnt = 5'h00;
                  end
               end else if (up_cnt != 5'h1F) begin
                  next_up_cnt = up_cnt + 5'h01;
               end
               // Reset pull-up (IC_USB strong, Section-7 token weak) until upstream high plus hold time
               if (up_seen && !up_done && (up_cnt == HOLD_CYC)) begin
                  next_up_done = 1'b1;
                  next_ic_strong = 1'b0;
                  next_s7_weak = 1'b0;
               end
               // Boost downstream D+ once the drive delay has passed
               if (up_seen && !down_done && (up_cnt >= DRIVE_DELAY_CYC)) begin
                  next_dp_out = 1'b1;
                  next_dp_oe = 1'b1;
                  if (down_dp) begin
                     if (down_cnt == HOLD_CYC) begin
                        next_down_done = 1'b1;
                        next_dp_out = 1'b0;
                        next_dp_oe = 1'b0;
                     end else begin
                        next_down_cnt = down_cnt + 5'h01;
                     end
                  end
               end else if (!up_seen) begin
                  next_dp_out = 1'b0;
                  next_dp_oe = 1'b1;
               end
               if (up_done && down_done) begin
                  next_state = ST_ATTACHED;
                  next_dp_oe = 1'b0;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_cnt = 5'h00;
         end
      endcase
   end
end

// ****************************************
// Sequencer registers
// ****************************************
always @(posedge sys_clk or negedge reset_n) begin
   if (!reset_n) begin
      state <= ST_IDLE;
      cnt <= 5'h00;
      up_cnt <= 5'h00;
      down_cnt <= 5'h00;
      up_seen <= 1'b0;
      up_done <= 1'b0;
      down_done <= 1'b0;
      long_se0 <= 1'b0;
      section7_pullup_switch <= 1'b0;
      section7_pullup_weak <= 1'b0;
      icusb_pullup_switch <= 1'b0;
      icusb_pullup_strong <= 1'b0;
      host_side_pulldown <= 2'b00;
      downstream_facing_pulldown <= 2'b00;
      down_dplus_out <= 1'b0;
      down_dplus_oe <= 1'b0;
      attach_confirmed <= 1'b0;
   end else begin
      state <= next_state;
      cnt <= next_cnt;
      up_cnt <= next_up_cnt;
      down_cnt <= next_down_cnt;
      up_seen <= next_up_seen;
      up_done <= next_up_done;
      down_done <= next_down_done;
      long_se0 <= next_long_se0;
      section7_pullup_switch <= next_s7_sw;
      section7_pullup_weak <= next_s7_weak;
      icusb_pullup_switch <= next_ic_sw;
      icusb_pullup_strong <= next_ic_strong;
      host_side_pulldown <= next_host_pd;
      downstream_facing_pulldown <= next_down_pd;
      down_dplus_out <= next_dp_out;
      down_dplus_oe <= next_dp_oe;
      attach_confirmed <= next_attach;
   end
end

endmodule // usb_attach_pullup_sequencer

// [design/usb_attach_defs.vh]
// Constants for the attach and pull resistor sequencer
`ifndef USB_ATTACH_DEFS_VH
`define USB_ATTACH_DEFS_VH

// ****************************************
// Timebase
// ****************************************
`define CLK_PERIOD_NS 50

// ****************************************
// Nominal delays and derived cycle counts
// ****************************************
`define ATTACH_DEBOUNCE_NS 200
`define ATTACH_DEBOUNCE_CYC ((`ATTACH_DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_SE0_NS 1000
`define LONG_SE0_CYC ((`LONG_SE0_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DRIVE_DELAY_NS 40
`define DRIVE_DELAY_CYC (((`DRIVE_DELAY_NS / `CLK_PERIOD_NS) > 0) ? (`DRIVE_DELAY_NS / `CLK_PERIOD_NS) : 1)
`define DOWN_LOW_NS 40
`define DOWN_LOW_CYC (((`DOWN_LOW_NS / `CLK_PERIOD_NS) > 0) ? (`DOWN_LOW_NS / `CLK_PERIOD_NS) : 1)
`define HOLD_NS 100
`define HOLD_CYC ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************
// Strap codes
// ****************************************
`define STRAP_CONVERTER 3'h7
`define STRAP_SECTION7 3'h6
`define STRAP_UNUSED 3'h4

// ****************************************
// Register map
// ****************************************
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_STATE 4'h8
`define CTRL_ENABLE_BIT 0
`define CTRL_TOKEN_BIT 1
`define CTRL_RESET 8'h03

`endif

// [design/pin_filter.v]
// Three-stage pin synchroniser that passes a level once two stages agree
`timescale 1ns/100ps
module pin_filter #(
   parameter WIDTH = 1
) (
   input wire sys_clk, // Timebase clock
   input wire reset_n, // Asynchronous reset, active low
   input wire [WIDTH-1:0] pin_in, // Raw pin levels
   output reg [WIDTH-1:0] level_out // Filtered levels
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;
reg [WIDTH-1:0] stage3;

genvar i;
generate
   for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            stage1[i] <= 1'b0;
            stage2[i] <= 1'b0;
            stage3[i] <= 1'b0;
            level_out[i] <= 1'b0;
         end else begin
            stage1[i] <= pin_in[i];
            stage2[i] <= stage1[i];
            stage3[i] <= stage2[i];
            // Take the level only once the later two stages agree
            if (stage2[i] == stage3[i]) begin
               level_out[i] <= stage3[i];
            end
         end
      end
   end
endgenerate

endmodule // pin_filter

// [testbench/usb_attach_checker.sv]
// Assertions on the sequencer pins
`timescale 1ns/100ps
module usb_attach_checker (
   input wire sys_clk, // Clock
   input wire reset_n, // Reset
   input wire [2:0] mode_strap, // Straps
   input wire up_dplus, // Up D+
   input wire up_dminus, // Up D-
   input wire down_dplus, // Down D+
   input wire section7_pullup_switch, // S7 on
   input wire section7_pullup_weak, // S7 2.2k
   input wire icusb_pullup_switch, // IC on
   input wire icusb_pullup_strong, // IC 2k
   input wire [1:0] host_side_pulldown, // Host pd
   input wire [1:0] downstream_facing_pulldown, // Down pd
   input wire down_dplus_out, // Drive level
   input wire down_dplus_oe, // Drive enable
   input wire attach_confirmed // Attach
);
   reg [5:0] hi_cnt;
   reg [5:0] se0_cnt;
   wire se0 = !up_dplus && !up_dminus;
   wire [9:0] outs = {section7_pullup_switch, section7_pullup_weak, icusb_pullup_switch, icusb_pullup_strong,
      host_side_pulldown, downstream_facing_pulldown, attach_confirmed, down_dplus_oe};
   // ****
   // Run lengths of raw line states
   // ****
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         hi_cnt <= 6'h00;
         se0_cnt <= 6'h00;
      end else begin
         hi_cnt <= !down_dplus ? 6'h00 : hi_cnt + {5'h00, hi_cnt != 6'h3F};
         se0_cnt <= !se0 ? 6'h00 : se0_cnt + {5'h00, se0_cnt != 6'h3F};
      end
   end
   default clocking dck @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   AST_DIGITAL_OFF:
      assert property (mode_strap[2:1] != 2'b11 |-> outs == 10'h000) else $error("digital code active");
   AST_CONV_NO_S7:
      assert property (mode_strap == 3'h7 |-> !section7_pullup_switch) else $error("s7 pull-up in converter");
   AST_TOKEN_NO_IC:
      assert property (mode_strap == 3'h6 |-> !icusb_pullup_switch && downstream_facing_pulldown == 2'b00)
         else $error("token switches closed");
   AST_DEBOUNCE:
      assert property ($rose(attach_confirmed) |-> hi_cnt > 6'h04) else $error("attach too early");
   AST_CONV_ATTACH:
      assert property ($rose(attach_confirmed) && mode_strap == 3'h7 |-> icusb_pullup_switch &&
         icusb_pullup_strong && host_side_pulldown == 2'b10) else $error("converter attach pulls");
   AST_TOKEN_ATTACH:
      assert property ($rose(attach_confirmed) && mode_strap == 3'h6 |-> section7_pullup_switch &&
         !section7_pullup_weak) else $error("token attach pull-up");
   AST_SE0_LOW:
      assert property (attach_confirmed && $fell(up_dplus) && !up_dminus |-> ##[1:6]
         (down_dplus_oe && !down_dplus_out)) else $error("down D+ not driven low");
   AST_LONG_SE0:
      assert property (down_dplus_oe && se0_cnt == 6'h1E |-> host_side_pulldown == 2'b00)
         else $error("host pull-downs kept");
   AST_SE0_EARLY:
      assert property ($fell(host_side_pulldown[1]) |-> se0_cnt > 6'h14) else $error("pull-downs dropped early");
   AST_CONV_RECOVER:
      assert property (mode_strap == 3'h7 && down_dplus_oe && $rose(up_dplus) |->
         (icusb_pullup_switch && icusb_pullup_strong) [*3] ##[1:8] !icusb_pullup_strong)
         else $error("converter pull-up strength");
   AST_TOKEN_RECOVER:
      assert property (mode_strap == 3'h6 && down_dplus_oe && $rose(up_dplus) |->
         (section7_pullup_switch && section7_pullup_weak) [*3] ##[1:8]
         (section7_pullup_switch && !section7_pullup_weak)) else $error("token pull-up strength");
   AST_TOKEN_RESET:
      assert property (mode_strap == 3'h6 && $rose(down_dplus_oe) |-> section7_pullup_switch &&
         section7_pullup_weak) else $error("token reset pull-up");
   AST_BOOST_START:
      assert property ($rose(down_dplus_out) |-> down_dplus_oe && $past(up_dplus)) else $error("boost start");
   AST_BOOST_HOLD:
      assert property ($fell(down_dplus_oe) && mode_strap[2:1] == 2'b11 |-> $past(down_dplus_out) &&
         hi_cnt > 6'h02) else $error("boost end");
endmodule // usb_attach_checker

bind usb_attach_pullup_sequencer usb_attach_checker chk_i (.sys_clk, .reset_n, .mode_strap, .up_dplus,
   .up_dminus, .down_dplus, .section7_pullup_switch, .section7_pullup_weak, .icusb_pullup_switch,
   .icusb_pullup_strong, .host_side_pulldown, .downstream_facing_pulldown, .down_dplus_out, .down_dplus_oe,
   .attach_confirmed);

// [testbench/usb_line_model.sv]
// Host and peripheral line model
`timescale 1ns/100ps
module usb_line_model #(
   parameter RISE_NS = 120
) (
   input wire host_se0, // Host drives SE0
   input wire periph_on, // Peripheral pull-up
   input wire section7_pullup_switch, // S7 on
   input wire icusb_pullup_switch, // IC on
   input wire down_dplus_out, // Drive level
   input wire down_dplus_oe, // Drive enable
   output wire up_dplus, // Up D+
   output wire up_dminus, // Up D-
   output wire down_dplus // Down D+
);
   // Slow rise through the pull-up, SE0 pulls low at once
   assign #(RISE_NS, 0) up_dplus = (section7_pullup_switch || icusb_pullup_switch) && !host_se0;
   assign up_dminus = 1'b0;
   assign down_dplus = down_dplus_oe ? down_dplus_out : periph_on;
endmodule // usb_line_model

// [testbench/tb_usb_attach_pullup_sequencer.sv]
// Bench for the attach sequencer
`timescale 1ns/100ps
module tb_usb_attach_pullup_sequencer;
   reg sys_clk;
   reg reset_n;
   reg [3:0] reg_addr;
   reg [7:0] reg_wdata;
   reg reg_write;
   reg reg_read;
   reg [2:0] mode_strap;
   reg host_se0;
   reg periph_on;
   wire [7:0] reg_rdata;
   wire up_dplus, up_dminus, down_dplus;
   wire s7_sw, s7_weak, ic_sw, ic_strong, dn_out, dn_oe, attach;
   wire [1:0] host_pd, down_pd;
   wire [7:0] obs = {s7_sw, s7_weak, ic_sw, ic_strong, host_pd, down_pd};
   wire [2:0] ev = {dn_oe, up_dplus, attach};
   int error_cnt = 0;
   int n_checks = 0;
   integer seed = 74;
   integer n;
   int i;
   usb_attach_pullup_sequencer dut (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .mode_strap, .up_dplus, .up_dminus, .down_dplus, .section7_pullup_switch(s7_sw),
      .section7_pullup_weak(s7_weak), .icusb_pullup_switch(ic_sw), .icusb_pullup_strong(ic_strong),
      .host_side_pulldown(host_pd), .downstream_facing_pulldown(down_pd), .down_dplus_out(dn_out),
      .down_dplus_oe(dn_oe), .attach_confirmed(attach));
   usb_line_model line (.host_se0, .periph_on, .section7_pullup_switch(s7_sw), .icusb_pullup_switch(ic_sw),
      .down_dplus_out(dn_out), .down_dplus_oe(dn_oe), .up_dplus, .up_dminus, .down_dplus);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      @(posedge sys_clk);
      chk(reg_rdata, exp);
   endtask
   task automatic boot(input logic [2:0] m);
      reset_n <= 1'b0;
      mode_strap <= m;
      periph_on <= 1'b0;
      host_se0 <= 1'b0;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic await(input int b, input logic v);
      int k;
      k = 0;
      while (ev[b] !== v && k < 100) begin
         @(posedge sys_clk);
         k++;
      end
      chk({7'h00, ev[b]}, {7'h00, v});
   endtask
   // ****
   // Attach, two bus resets, detach
   // ****
   task automatic seq(input logic [2:0] m);
      logic cv;
      logic [7:0] pre;
      cv = (m == 3'h7);
      pre = cv ? 8'h0F : 8'h0C;
      boot(m);
      chk(obs, pre);
      periph_on <= 1'b1;
      repeat (1 + {$random(seed)} % 3) @(posedge sys_clk);
      periph_on <= 1'b0;
      repeat (12) @(posedge sys_clk);
      chk({7'h00, attach}, 8'h00);
      periph_on <= 1'b1;
      await(0, 1'b1);
      chk(obs & (cv ? 8'hFC : 8'hF0), cv ? 8'h38 : 8'h80);
      await(1, 1'b1);
      // Host waits for a settled connect before reset
      repeat (8) @(posedge sys_clk);
      repeat (2) begin
         host_se0 <= 1'b1;
         n = 32 + {$random(seed)} % 16;
         await(2, 1'b1);
         chk({5'h00, dn_oe, dn_out, s7_weak}, {7'h02, !cv});
         repeat (n) @(posedge sys_clk);
         chk(obs & 8'h0C, 8'h00);
         rd(4'h4, {2'h0, m, 3'h7});
         host_se0 <= 1'b0;
         await(2, 1'b0);
         repeat (4) @(posedge sys_clk);
         chk(obs & 8'hF0, cv ? 8'h20 : 8'h80);
         rd(4'h8, 8'h04);
      end
      periph_on <= 1'b0;
      await(0, 1'b0);
      repeat (6) @(posedge sys_clk);
      chk(obs, pre);
      $display("attach sequence strap %0d done", m);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      #500000;
      error_cnt++;
      close_out;
   end
   initial begin
      reset_n = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      mode_strap = 3'h7;
      host_se0 = 1'b0;
      periph_on = 1'b0;
      @(posedge sys_clk);
      for (i = 0; i < 6; i++) begin
         boot(i[2:0]);
         n = $random(seed);
         periph_on <= n[0];
         repeat (16) @(posedge sys_clk);
         chk({obs[7:2], attach, dn_oe}, 8'h00);
      end
      $display("digital strap codes done");
      boot(3'h7);
      rd(4'h0, 8'h03);
      rd(4'h8, 8'h01);
      rd(4'h4, 8'h38);
      n = $random(seed);
      wr(4'hC, n[7:0]);
      rd(4'hC, 8'h00);
      wr(4'h4, n[7:0]);
      wr(4'h8, n[7:0]);
      rd(4'h8, 8'h01);
      wr(4'h0, 8'h00);
      repeat (3) @(posedge sys_clk);
      chk(obs, 8'h00);
      rd(4'h0, 8'h00);
      wr(4'h0, 8'h03);
      repeat (3) @(posedge sys_clk);
      chk(obs, 8'h0F);
      $display("register and enable test done");
      seq(3'h7);
      seq(3'h6);
      close_out;
   end
endmodule // tb_usb_attach_pullup_sequencer
